/* File: pli_indicator.v */
`timescale 1ns/1ps
`include "pli_regs.vh"

module pli_indicator (
   input  wire       isSecond,
   input  wire [1:0] style,
   input  wire [3:0] code,
   input  wire       forceOff,
   input  wire       linkUp,
   input  wire [1:0] speed,
   input  wire       fullDuplex,
   input  wire       activity,
   input  wire       collision,
   input  wire       pdFault,
   input  wire       blinkPhase,
   output reg        lightOn
);

   // Bit n set: speed code n is shown
   function [2:0] speedMask;
      input [3:0] c;
      begin
         case (c)
            `PLI_EC_LINK:      speedMask = 3'h7;
            `PLI_EC_L1000:     speedMask = 3'h4;
            `PLI_EC_L100:      speedMask = 3'h2;
            `PLI_EC_L10:       speedMask = 3'h1;
            `PLI_EC_L100_1000: speedMask = 3'h6;
            `PLI_EC_L10_1000:  speedMask = 3'h5;
            `PLI_EC_L10_100:   speedMask = 3'h3;
            default:           speedMask = 3'h0;
         endcase
      end
   endfunction

   wire [2:0] spdHot = (speed == `PLI_SPD_1000) ? 3'h4 :
                       (speed == `PLI_SPD_100)  ? 3'h2 :
                       (speed == `PLI_SPD_10)   ? 3'h1 : 3'h0;
   wire       actShow = activity ? blinkPhase : 1'b1;
   wire       triUse  = isSecond ? |(spdHot & 3'h5) : |(spdHot & 3'h3);

   always @* begin
      lightOn = 1'b0;
      if (forceOff) begin
         lightOn = 1'b0; // RULE8
      end else begin
         case (style)
            `PLI_STY_IND: begin
               lightOn = isSecond ? linkUp : (linkUp & activity & blinkPhase); // RULE9 RULE10
            end
            `PLI_STY_TRI: begin
               lightOn = linkUp & triUse & actShow; // RULE11 RULE12
            end
            `PLI_STY_ENH: begin
               case (code) // RULE13
                  `PLI_EC_LINK: lightOn = linkUp & actShow; // RULE15
                  `PLI_EC_L1000, `PLI_EC_L100, `PLI_EC_L10: lightOn = linkUp & |(speedMask(code) & spdHot) & actShow; // RULE16
                  `PLI_EC_L100_1000, `PLI_EC_L10_1000, `PLI_EC_L10_100: begin
                     lightOn = linkUp & |(speedMask(code) & spdHot) & actShow; // RULE17
                  end
                  `PLI_EC_DUPLEX: lightOn = linkUp & (fullDuplex | (collision & blinkPhase)); // RULE18
                  `PLI_EC_COLL:   lightOn = collision & blinkPhase; // RULE19
                  `PLI_EC_ACT:    lightOn = activity & blinkPhase; // RULE19
                  `PLI_EC_PDF:    lightOn = pdFault; // RULE20
                  `PLI_EC_OFF:    lightOn = 1'b0;
                  `PLI_EC_ON:     lightOn = 1'b1;
                  default:        lightOn = 1'b0; // RULE21
               endcase
            end
            default: lightOn = 1'b0;
         endcase
      end
   end

endmodule // pli_indicator

/* File: pli_led_lamps.sv */
`timescale 1ns/1ps
module pli_led_lamps (
   input  wire [7:0] pinOut,
   input  wire [7:0] pinOe_n,
   input  wire [7:0] activeHigh,
   output wire [7:0] pinLevel,
   output wire [7:0] lampOn
);
   // Released pin rests at the lamp-off level through its resistor
   assign pinLevel = (pinOut & ~pinOe_n) | (~activeHigh & pinOe_n);
   assign lampOn   = ~(pinLevel ^ activeHigh);
endmodule // pli_led_lamps

/* File: pli_regs.vh */
`ifndef PLI_REGS_VH
`define PLI_REGS_VH

// Register byte addresses
`define PLI_CTRLA_BASE   8'h00
`define PLI_CTRLB_BASE   8'h10
`define PLI_BEHAV_ADDR   8'h20
`define PLI_PINCFG_ADDR  8'h24
`define PLI_STATUS_ADDR  8'h28

// Register index codes used by the address decoder
`define PLI_IDX_CTRLA    3'h0
`define PLI_IDX_CTRLB    3'h1
`define PLI_IDX_BEHAV    3'h2
`define PLI_IDX_PINCFG   3'h3
`define PLI_IDX_STATUS   3'h4
`define PLI_IDX_NONE     3'h7

// First control register fields
`define PLI_A_ISO        0
`define PLI_A_PDN        1
`define PLI_A_STYLE      6
`define PLI_CTRLA_RST    7'h40

// Second control register fields
`define PLI_B_CODEA_LSB  0
`define PLI_B_CODEB_LSB  4
`define PLI_CTRLB_RST    8'h00

// Behaviour register fields
`define PLI_BH_RATE_LSB  0
`define PLI_BH_STRETCH   2
`define PLI_BEHAV_RST    3'h1

// Pin configuration fields
`define PLI_PC_EN_LSB    0
`define PLI_PC_OD_LSB    8
`define PLI_PC_POL_LSB   16
`define PLI_PINCFG_RST   24'h000000

// Status register fields
`define PLI_ST_COMA      8
`define PLI_ST_STRAP     9

// Display styles
`define PLI_STY_IND      2'h0
`define PLI_STY_TRI      2'h1
`define PLI_STY_ENH      2'h2

// Link speed codes
`define PLI_SPD_10       2'h0
`define PLI_SPD_100      2'h1
`define PLI_SPD_1000     2'h2

// Enhanced codes
`define PLI_EC_LINK      4'h0
`define PLI_EC_L1000     4'h1
`define PLI_EC_L100      4'h2
`define PLI_EC_L10       4'h3
`define PLI_EC_L100_1000 4'h4
`define PLI_EC_L10_1000  4'h5
`define PLI_EC_L10_100   4'h6
`define PLI_EC_DUPLEX    4'h8
`define PLI_EC_COLL      4'h9
`define PLI_EC_ACT       4'ha
`define PLI_EC_PDF       4'hc
`define PLI_EC_OFF       4'he
`define PLI_EC_ON        4'hf

// Timing
`define PLI_CLK_NS       50
`define PLI_MS_NS        1000000
`define PLI_MS_CNT_W     16
`define PLI_HALF_0_MS    9'h032
`define PLI_HALF_1_MS    9'h064
`define PLI_HALF_2_MS    9'h0c8
`define PLI_HALF_3_MS    9'h190
`define PLI_STRAP_WAIT   2'h3

// AXI responses
`define PLI_RESP_OKAY    2'h0
`define PLI_RESP_SLVERR  2'h2

`endif

/* File: pli_top.v */
// Summary of operation
// RULE1: Eight indicators, two per port, programmable.
// RULE2: Style bit and strap pick display style.
// RULE3: Strap sets default; per-port registers override.
// RULE4: Software enables pin, driver type first.
// RULE5: Open-drain type follows polarity automatically.
// RULE6: Polarity straps give default pin polarity.
// RULE7: Coma disables indicators; leaving restores them.
// RULE8: Isolate, power-down or coma force off.
// RULE9: Individual: second shows link, first activity.
// RULE10: Individual: link steady, activity blinks first.
// RULE11: Tri-color: speed picks which indicators light.
// RULE12: Tri-color: steady idle, blink on activity.
// RULE13: Enhanced: each indicator uses own code.
// RULE14: Blink rate, stretching from behaviour register.
// RULE15: Code 0: link any speed with activity.
// RULE16: Codes 1-3: link-activity at single speed.
// RULE17: Codes 4-6: link-activity at speed pairs.
// RULE18: Code 8: duplex steady, half collisions blink.
// RULE19: Code 9 collision blink, 10 activity.
// RULE20: Code 12 shows parallel detect fault.
// RULE21: Reserved codes dark; blink uses set rate.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pli_regs.vh"

module pli_top #(
   parameter TICK_CYCLES = `PLI_MS_NS / `PLI_CLK_NS
) (
   input  wire        mclk,
   input  wire        reset,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [3:0]  linkUp,
   input  wire [7:0]  linkSpeed,
   input  wire [3:0]  fullDuplex,
   input  wire [3:0]  activity,
   input  wire [3:0]  collision,
   input  wire [3:0]  pdFault,
   input  wire        comaPin,
   input  wire        indicatorStyleStrap,
   input  wire [7:0]  indicatorPolarityStraps,
   output reg  [7:0]  indicatorOut,
   output reg  [7:0]  indicatorOe_n
);

   // Index from address; shared by read and write paths
   function [2:0] regIndex;
      input [7:0] a;
      begin
         if (a[1:0] != 2'h0)
            regIndex = `PLI_IDX_NONE;
         else if (a >= `PLI_CTRLA_BASE && a < `PLI_CTRLB_BASE)
            regIndex = `PLI_IDX_CTRLA;
         else if (a >= `PLI_CTRLB_BASE && a < `PLI_BEHAV_ADDR)
            regIndex = `PLI_IDX_CTRLB;
         else if (a == `PLI_BEHAV_ADDR)
            regIndex = `PLI_IDX_BEHAV;
         else if (a == `PLI_PINCFG_ADDR)
            regIndex = `PLI_IDX_PINCFG;
         else if (a == `PLI_STATUS_ADDR)
            regIndex = `PLI_IDX_STATUS;
         else
            regIndex = `PLI_IDX_NONE;
      end
   endfunction

   // Byte-lane merge
   function [31:0] laneMerge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0]  strb;
      integer i;
      begin
         laneMerge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
               laneMerge[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
   endfunction

   // Pin synchronisers
   reg        comaMeta_ff;
   reg        coma_ff;
   reg [8:0]  strapMeta_ff;
   reg [8:0]  strapSync_ff;
   reg [1:0]  strapCnt_ff;
   reg        styleStrap_ff;

   always @(posedge mclk) begin
      comaMeta_ff  <= comaPin;
      coma_ff      <= comaMeta_ff;
      strapMeta_ff <= {indicatorStyleStrap, indicatorPolarityStraps};
      strapSync_ff <= strapMeta_ff;
   end

   // Straps are caught once the synchroniser has filled after reset
   wire strapLoad = (strapCnt_ff == `PLI_STRAP_WAIT - 2'h1);

   always @(posedge mclk) begin
      if (reset) begin
         strapCnt_ff   <= 2'h0;
         styleStrap_ff <= 1'b0;
      end else begin
         if (strapCnt_ff != `PLI_STRAP_WAIT)
            strapCnt_ff <= strapCnt_ff + 2'h1;
         if (strapLoad)
            styleStrap_ff <= strapSync_ff[8]; // RULE3
      end
   end

   // AXI4-Lite write path
   reg        awHeld_ff;
   reg [7:0]  awAddr_ff;
   reg        wHeld_ff;
   reg [31:0] wData_ff;
   reg [3:0]  wStrb_ff;

   assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_ff && !s_axi_bvalid;

   wire       doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
   wire [2:0] wIdx    = regIndex(awAddr_ff);
   wire [1:0] wPort   = awAddr_ff[3:2];

   always @(posedge mclk) begin
      if (reset) begin
         awHeld_ff    <= 1'b0;
         awAddr_ff    <= 8'h00;
         wHeld_ff     <= 1'b0;
         wData_ff     <= 32'h00000000;
         wStrb_ff     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PLI_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_ff    <= 1'b0;
            wHeld_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wIdx == `PLI_IDX_NONE || wIdx == `PLI_IDX_STATUS) ?
                            `PLI_RESP_SLVERR : `PLI_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers
   reg [6:0]  ctrlA_ff [0:3];
   reg [7:0]  ctrlB_ff [0:3];
   reg [2:0]  behav_ff;
   reg [23:0] pinCfg_ff;
   reg [7:0]  ledOn_ff;

   wire [31:0] mergeA  = laneMerge({25'h0, ctrlA_ff[wPort]}, wData_ff, wStrb_ff);
   wire [31:0] mergeB  = laneMerge({24'h0, ctrlB_ff[wPort]}, wData_ff, wStrb_ff);
   wire [31:0] mergeBh = laneMerge({29'h0, behav_ff}, wData_ff, wStrb_ff);
   wire [31:0] mergePc = laneMerge({8'h0, pinCfg_ff}, wData_ff, wStrb_ff);

   integer k;
   always @(posedge mclk) begin
      if (reset) begin
         for (k = 0; k < 4; k = k + 1) begin
            ctrlA_ff[k] <= `PLI_CTRLA_RST;
            ctrlB_ff[k] <= `PLI_CTRLB_RST;
         end
         behav_ff  <= `PLI_BEHAV_RST;
         pinCfg_ff <= `PLI_PINCFG_RST;
      end else begin
         if (doWrite && wIdx == `PLI_IDX_CTRLA)
            ctrlA_ff[wPort] <= mergeA[6:0];
         if (doWrite && wIdx == `PLI_IDX_CTRLB)
            ctrlB_ff[wPort] <= mergeB[7:0];
         if (doWrite && wIdx == `PLI_IDX_BEHAV)
            behav_ff <= mergeBh[2:0]; // RULE14
         if (doWrite && wIdx == `PLI_IDX_PINCFG)
            pinCfg_ff <= mergePc[23:0]; // RULE4
         else if (strapLoad)
            // Pull-up strap means active-low pin, hence the inversion
            pinCfg_ff[`PLI_PC_POL_LSB +: 8] <= ~strapSync_ff[7:0]; // RULE6
      end
   end

   // AXI4-Lite read path
   wire [2:0] rIdx  = regIndex(s_axi_araddr);
   wire [1:0] rPort = s_axi_araddr[3:2];
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge mclk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `PLI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `PLI_RESP_OKAY;
         case (rIdx)
            `PLI_IDX_CTRLA:  s_axi_rdata <= {25'h0, ctrlA_ff[rPort]};
            `PLI_IDX_CTRLB:  s_axi_rdata <= {24'h0, ctrlB_ff[rPort]};
            `PLI_IDX_BEHAV:  s_axi_rdata <= {29'h0, behav_ff};
            `PLI_IDX_PINCFG: s_axi_rdata <= {8'h0, pinCfg_ff};
            `PLI_IDX_STATUS: s_axi_rdata <= {22'h0, styleStrap_ff, coma_ff, ledOn_ff};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `PLI_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Millisecond tick and blink phase
   reg [`PLI_MS_CNT_W-1:0] msCnt_ff;
   reg [8:0]               halfCnt_ff;
   reg                     blinkPhase_ff;
   reg [8:0]               halfLimit;

   wire msTick     = (msCnt_ff == TICK_CYCLES[`PLI_MS_CNT_W-1:0] - 1'b1);
   wire phaseFlip  = msTick && (halfCnt_ff >= halfLimit - 9'h001);

   always @* begin
      case (behav_ff[`PLI_BH_RATE_LSB +: 2])
         2'h0:    halfLimit = `PLI_HALF_0_MS;
         2'h1:    halfLimit = `PLI_HALF_1_MS;
         2'h2:    halfLimit = `PLI_HALF_2_MS;
         default: halfLimit = `PLI_HALF_3_MS;
      endcase
   end

   always @(posedge mclk) begin
      if (reset) begin
         msCnt_ff      <= {`PLI_MS_CNT_W{1'b0}};
         halfCnt_ff    <= 9'h000;
         blinkPhase_ff <= 1'b0;
      end else begin
         msCnt_ff <= msTick ? {`PLI_MS_CNT_W{1'b0}} : msCnt_ff + 1'b1;
         if (phaseFlip) begin
            halfCnt_ff    <= 9'h000;
            blinkPhase_ff <= ~blinkPhase_ff; // RULE21
         end else if (msTick) begin
            halfCnt_ff <= halfCnt_ff + 9'h001;
         end
      end
   end

   // Stretch: short bursts stay visible until the next phase change
   reg [3:0] actHold_ff;
   reg [3:0] colHold_ff;
   wire      stretchEn = behav_ff[`PLI_BH_STRETCH];

   always @(posedge mclk) begin
      if (reset) begin
         actHold_ff <= 4'h0;
         colHold_ff <= 4'h0;
      end else begin
         // New event wins over the clear at a phase change
         actHold_ff <= activity  | (phaseFlip ? 4'h0 : actHold_ff);
         colHold_ff <= collision | (phaseFlip ? 4'h0 : colHold_ff);
      end
   end

   wire [3:0] actEff = stretchEn ? (actHold_ff | activity) : activity; // RULE14
   wire [3:0] colEff = stretchEn ? (colHold_ff | collision) : collision;

   // Eight indicators
   wire [7:0] lightNow;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : gInd
         localparam P = g / 2;
         wire [6:0] regA   = ctrlA_ff[P];
         wire [7:0] regB   = ctrlB_ff[P];
         wire       second = (g % 2) == 1;
         wire [1:0] sty    = !regA[`PLI_A_STYLE] ? `PLI_STY_ENH :
                             (styleStrap_ff ? `PLI_STY_IND : `PLI_STY_TRI); // RULE2 RULE3
         wire       offNow = regA[`PLI_A_ISO] | regA[`PLI_A_PDN] | coma_ff; // RULE7 RULE8
         wire [3:0] code   = second ? regB[`PLI_B_CODEB_LSB +: 4] : regB[`PLI_B_CODEA_LSB +: 4];

         pli_indicator uInd (
            .isSecond   (second),
            .style      (sty),
            .code       (code),
            .forceOff   (offNow),
            .linkUp     (linkUp[P]),
            .speed      (linkSpeed[2*P +: 2]),
            .fullDuplex (fullDuplex[P]),
            .activity   (actEff[P]),
            .collision  (colEff[P]),
            .pdFault    (pdFault[P]),
            .blinkPhase (blinkPhase_ff),
            .lightOn    (lightNow[g])
         ); // RULE1
      end
   endgenerate

   // Pin drivers
   wire [7:0] pinEn  = pinCfg_ff[`PLI_PC_EN_LSB +: 8];
   wire [7:0] pinOd  = pinCfg_ff[`PLI_PC_OD_LSB +: 8];
   wire [7:0] pinPol = pinCfg_ff[`PLI_PC_POL_LSB +: 8];

   always @(posedge mclk) begin
      if (reset) begin
         ledOn_ff      <= 8'h00;
         indicatorOut  <= 8'h00;
         indicatorOe_n <= 8'hff;
      end else begin
         ledOn_ff      <= lightNow;
         // Level equals polarity when lit
         indicatorOut  <= pinEn & ~(lightNow ^ pinPol);
         // Open-drain releases when dark: open-source if active high
         indicatorOe_n <= ~pinEn | (pinOd & ~lightNow); // RULE4 RULE5
      end
   end

endmodule // pli_top

/* File: pli_top_monitor.sv */
`timescale 1ns/1ps
module pli_top_monitor #(
   parameter TICK_CYCLES = 4
) (
   input wire        mclk,
   input wire        reset,
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        comaPin,
   input wire [7:0]  indicatorOut,
   input wire [7:0]  indicatorOe_n
);
   logic [3:0] comaCnt_ff;
   logic [3:0] nxt_comaCnt;

   assign nxt_comaCnt = !comaPin ? 4'h0 : comaCnt_ff + {3'h0, comaCnt_ff != 4'hf};
   always @(posedge mclk) begin
      if (reset) begin
         comaCnt_ff <= 4'h0;
      end else begin
         comaCnt_ff <= nxt_comaCnt;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence errAnswer;
      s_axi_bvalid && s_axi_bresp == 2'h2;
   endsequence

   a_reset_quiet: assert property (disable iff (1'b0) reset |=>
      indicatorOe_n == 8'hff && indicatorOut == 8'h00 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not quiet after reset");
   a_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_bad_write: assert property (wrTaken ##0 s_axi_awaddr >= 8'h28 |-> ##[1:2] errAnswer)
      else $error("bad write not refused");
   a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_answer: assert property (rdTaken |=> s_axi_rvalid)
      else $error("read data missing");
   a_bad_read: assert property (rdTaken ##0 s_axi_araddr > 8'h28 |=>
      s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)
      else $error("unmapped read wrong");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !$past(s_axi_arready))
      else $error("read data repeated");
   a_coma_dark: assert property (
      comaCnt_ff >= 4'h5 && !s_axi_bvalid && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)
      |-> $stable(indicatorOut) && $stable(indicatorOe_n))
      else $error("pins move during coma");
endmodule // pli_top_monitor

bind pli_top pli_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (.mclk, .reset, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .comaPin, .indicatorOut, .indicatorOe_n);

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "pli_regs.vh"
module tb_top;
   localparam int TICK = 4;
   logic        mclk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        comaPin, indicatorStyleStrap;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, linkSpeed, indicatorPolarityStraps;
   logic [31:0] s_axi_wdata, rd;
   logic [3:0]  s_axi_wstrb, linkUp, fullDuplex, activity, collision, pdFault;
   logic [1:0]  resp;
   logic [7:0]  onSeen, offSeen;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [7:0]  indicatorOut, indicatorOe_n, pinLevel, lampOn;
   int          nFail, testsRun, cycles;

   pli_top #(.TICK_CYCLES(TICK)) dut_u (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .linkUp, .linkSpeed, .fullDuplex, .activity, .collision, .pdFault, .comaPin,
      .indicatorStyleStrap, .indicatorPolarityStraps, .indicatorOut, .indicatorOe_n);
   pli_led_lamps lamps_u (.pinOut(indicatorOut), .pinOe_n(indicatorOe_n), .activeHigh(8'hff),
      .pinLevel(pinLevel), .lampOn(lampOn));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         nFail++;
         $display("mismatch t=%0t timeout", $time);
         endOfTest();
      end
   end

   task endOfTest;
      if (nFail == 0 && testsRun > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         nFail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge mclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge mclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task setIn(input logic [3:0] lu, input logic [7:0] sp, input logic [3:0] fd, ac, co, pf);
      @(posedge mclk);
      linkUp     <= lu;
      linkSpeed  <= sp;
      fullDuplex <= fd;
      activity   <= ac;
      collision  <= co;
      pdFault    <= pf;
   endtask

   // Steady set l, blinking set b; 450 cycles span both phases
   task expectLamps(input logic [7:0] l, input logic [7:0] b);
      onSeen  = 8'h00;
      offSeen = 8'h00;
      repeat (4) @(posedge mclk);
      repeat (450) begin
         @(posedge mclk);
         onSeen  = onSeen | lampOn;
         offSeen = offSeen | ~lampOn;
      end
      check({24'h0, onSeen}, {24'h0, l | b});
      check({24'h0, offSeen}, {24'h0, ~l | b});
   endtask

   task doReset(input logic strap);
      @(posedge mclk);
      reset               <= 1'b1;
      indicatorStyleStrap <= strap;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask

   task setup;
      axiWrite(`PLI_BEHAV_ADDR, 32'h0, resp);
      axiWrite(`PLI_PINCFG_ADDR, 32'h00ff00ff, resp);
   endtask

   task tRegs;
      axiRead(8'h0c, rd, resp);
      check(rd, 32'h40);
      axiRead(8'h14, rd, resp);
      check(rd, 32'h0);
      axiRead(`PLI_BEHAV_ADDR, rd, resp);
      check(rd, 32'h1);
      axiRead(`PLI_PINCFG_ADDR, rd, resp);
      check(rd, {8'h0, ~indicatorPolarityStraps, 16'h0});
      axiRead(`PLI_STATUS_ADDR, rd, resp);
      check(rd, 32'h200);
      axiRead(8'h30, rd, resp);
      check({rd[29:0], resp}, {30'h0, `PLI_RESP_SLVERR});
      axiWrite(`PLI_STATUS_ADDR, 32'hff, resp);
      check({30'h0, resp}, {30'h0, `PLI_RESP_SLVERR});
   endtask

   task tPins;
      logic [31:0] cfg [5];
      logic [3:0]  pinExp [5];
      cfg    = '{32'h0, 32'h00ff00ff, 32'h000000ff, 32'h00ffffff, 32'h0000ffff};
      pinExp = '{4'b1100, 4'b0010, 4'b0001, 4'b0110, 4'b0101};
      axiWrite(8'h00, 32'h0, resp);
      axiWrite(8'h10, 32'hfe, resp);
      for (int i = 0; i < 5; i++) begin
         axiWrite(`PLI_PINCFG_ADDR, cfg[i], resp);
         repeat (3) @(posedge mclk);
         check({28'h0, indicatorOe_n[1:0], indicatorOut[1:0]}, {28'h0, pinExp[i]});
      end
      axiWrite(`PLI_PINCFG_ADDR, 32'h00ff00ff, resp);
   endtask

   task tIndividual;
      axiWrite(8'h00, 32'h40, resp);
      axiWrite(8'h0c, 32'h41, resp);
      setIn(4'b1110, 8'h00, 4'h0, 4'b1100, 4'h0, 4'h0);
      expectLamps(8'h28, 8'h10);
      axiWrite(8'h0c, 32'h42, resp);
      expectLamps(8'h28, 8'h10);
      axiWrite(8'h0c, 32'h40, resp);
      expectLamps(8'ha8, 8'h50);
      @(posedge mclk);
      comaPin <= 1'b1;
      expectLamps(8'h00, 8'h00);
      comaPin <= 1'b0;
      expectLamps(8'ha8, 8'h50);
   endtask

   task tEnhanced;
      logic [7:0] spMask [3];
      spMask = '{8'h69, 8'h55, 8'h33};
      for (int p = 0; p < 4; p++) begin
         axiWrite(8'(4 * p), 32'h0, resp);
         axiWrite(8'(16 + 4 * p), {24'h0, 4'(2 * p + 1), 4'(2 * p)}, resp);
      end
      for (int s = 0; s < 3; s++) begin
         setIn(4'hf, {4{2'(s)}}, 4'h0, 4'h0, 4'h0, 4'h0);
         expectLamps(spMask[s], 8'h00);
         setIn(4'hf, {4{2'(s)}}, 4'h0, 4'hf, 4'h0, 4'h0);
         expectLamps(8'h00, spMask[s]);
      end
      setIn(4'h0, 8'h00, 4'h0, 4'hf, 4'h0, 4'h0);
      expectLamps(8'h00, 8'h00);
      axiWrite(8'h10, 32'h89, resp);
      axiWrite(8'h14, 32'hca, resp);
      axiWrite(8'h18, 32'hdb, resp);
      axiWrite(8'h1c, 32'h88, resp);
      setIn(4'hf, 8'haa, 4'b1000, 4'b0110, 4'b0101, 4'b0110);
      expectLamps(8'hc8, 8'h07);
   endtask

   task tTri;
      axiRead(`PLI_STATUS_ADDR, rd, resp);
      check(rd & 32'h200, 32'h0);
      setIn(4'b0111, 8'h06, 4'h0, 4'b0101, 4'h0, 4'h0);
      expectLamps(8'h04, 8'h32);
      axiWrite(8'h0c, 32'h0, resp);
      axiWrite(8'h1c, 32'hf0, resp);
      expectLamps(8'h84, 8'h32);
   endtask

   task tRate;
      int   n;
      logic prev;
      int   halfMs [4];
      halfMs = '{50, 100, 200, 400};
      for (int r = 0; r < 4; r++) begin
         axiWrite(`PLI_BEHAV_ADDR, 32'(r), resp);
         prev = lampOn[1];
         while (lampOn[1] === prev) @(posedge mclk);
         prev = lampOn[1];
         n    = 0;
         while (lampOn[1] === prev) begin
            @(posedge mclk);
            n++;
         end
         check(n, TICK * halfMs[r]);
      end
      axiWrite(8'h1c, 32'hfa, resp);
      axiWrite(`PLI_BEHAV_ADDR, 32'h4, resp);
      while (lampOn[1]) @(posedge mclk);
      while (!lampOn[1]) @(posedge mclk);
      activity <= 4'hd;
      @(posedge mclk);
      activity <= 4'h5;
      repeat (9) @(posedge mclk);
      check({31'h0, lampOn[6]}, 32'h1);
   endtask

   initial begin
      reset = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {linkUp, fullDuplex, activity, collision, pdFault} = 20'h0;
      linkSpeed = 8'h00;
      comaPin = 1'b0;
      indicatorStyleStrap = 1'b1;
      indicatorPolarityStraps = 8'h5a;
      {nFail, testsRun, cycles} = 96'h0;
      doReset(1'b1);
      tRegs();
      setup();
      tPins();
      tIndividual();
      tEnhanced();
      doReset(1'b0);
      setup();
      tTri();
      tRate();
      endOfTest();
   end
endmodule // tb_top
